/* bench/mps_chk_sva.sv */
// checker: bus handshake, reset state and loop status of the search block
// assumes it is bound to the design top and sees only its ports
`default_nettype none
module mps_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [15:0] phase_a_out_r,
  input wire logic loop_closed_r,
  input wire logic commutating_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_req_answer: assert property (s_taken |=> s_done)
    else $error("bus request not answered next cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_high: assert property (!avs_read && !avs_write
    && !$past(avs_read) && !$past(avs_write) |-> avs_waitrequest)
    else $error("waitrequest low while idle");
  a_reset_state: assert property (@(posedge clk) disable iff (1'b0)
    sys_rst |=> phase_a_out_r == 16'h0000 && avs_waitrequest
    && !loop_closed_r && !commutating_r)
    else $error("outputs not cleared by reset");
  a_unmapped_zero: assert property (avs_read && avs_waitrequest
    && avs_address > 4'h6 |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_status_loop: assert property (
    avs_read && avs_waitrequest && avs_address == 4'h4
    |=> avs_readdata[3:2] == $past({commutating_r, loop_closed_r}))
    else $error("status loop bits disagree with outputs");
  a_loop_comm: assert property (loop_closed_r |-> commutating_r)
    else $error("loop closed without commutation");
  a_loop_open_cause: assert property ($fell(loop_closed_r)
    |-> $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
    else $error("loop opened without a command");
  cover property ($rose(loop_closed_r));
endmodule // mps_chk
bind mps_motor_phasing_search mps_chk chk (.clk(clk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .phase_a_out_r(phase_a_out_r), .loop_closed_r(loop_closed_r),
  .commutating_r(commutating_r));
`default_nettype wire

/* bench/mps_motor_model.sv */
// model of motor and encoder: shaft settles where phase a current pulls it
// assumes signed phase outputs and a servo tick pulse from the bench
`default_nettype none
module mps_motor_model (
  input wire logic clk,
  input wire logic servo_tick,
  input wire logic move_en,
  input wire logic [15:0] phase_a,
  output var logic [31:0] enc_position
);
  timeunit 1ns;
  timeprecision 1ns;
  initial enc_position = 32'h00001000;
  // positive drive counts up; a stuck shaft holds its count
  always @(posedge clk) begin
    if (servo_tick && move_en) begin
      enc_position <= 32'h00001000 + {{20{phase_a[15]}}, phase_a[15:4]};
    end
  end
endmodule // mps_motor_model
`default_nettype wire

/* bench/mps_motor_phasing_search_bench.sv */
// bench for the phasing search block: bus tasks and search scenarios
// assumes the motor model drives the encoder and the checker is bound
`default_nettype none
module mps_motor_phasing_search_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic servo_tick = 1'b0;
  logic amp_fault = 1'b0;
  logic limit_hit = 1'b0;
  logic move_en = 1'b1;
  logic [15:0] servo_cmd = 16'h0123;
  logic [31:0] rd;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [31:0] enc;
  wire [15:0] pha;
  wire [15:0] phb;
  wire closed;
  wire comm;
  wire [7:0] angle_out;
  int fails = 0;
  int compares = 0;
  mps_motor_phasing_search dut (.clk(clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .servo_tick(servo_tick),
    .enc_position(enc), .amp_fault(amp_fault), .limit_hit(limit_hit),
    .servo_cmd(servo_cmd), .phase_a_out_r(pha), .phase_b_out_r(phb),
    .comm_angle_r(angle_out), .loop_closed_r(closed),
    .commutating_r(comm));
  mps_motor_model motor (.clk(clk), .servo_tick(servo_tick),
    .move_en(move_en), .phase_a(pha), .enc_position(enc));
  initial forever #10 clk = ~clk;
  always @(posedge clk) servo_tick <= ~servo_tick;
  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
    if (n >= 100) begin
      fails++;
      $display("Error at %0t: bus answer timed out", $time);
      conclude();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdw(input logic [3:0] a);
    bus(1'b0, a, 32'h00000000, rd);
  endtask
  task automatic ticks(input int n);
    repeat (2 * n) @(posedge clk);
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    ticks(3);
    do begin
      rdw(4'h4);
      n++;
    end while (rd[0] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      fails++;
      $display("Error at %0t: search never went idle", $time);
      conclude();
    end
  endtask
  task automatic t_regs;
    rdw(4'h1);
    check(rd, 32'h00000FA0);
    rdw(4'h2);
    check(rd, 32'h00000005);
    rdw(4'h3);
    check(rd, 32'h00000055);
    wr(4'h4, 32'h0000000F);
    rdw(4'h4);
    check(rd, 32'h00000000);
    wr(4'hF, 32'hFFFFFFFF);
    rdw(4'hF);
    check(rd, 32'h00000000);
    $display("t_regs done");
  endtask
  task automatic t_boot(input logic [1:0] m, input logic e,
    input logic [31:0] exp);
    sys_rst <= 1'b1;
    amp_fault <= 1'b1;
    limit_hit <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    wr(4'h2, 32'h00000001);
    wr(4'h0, {29'h0, e, m});
    wait_idle();
    check(rd, exp);
    if (e && !m[0]) begin
      wr(4'h0, {28'h0000000, 2'b11, m});
      wait_idle();
      check(rd, m[1] ? 32'h00000002 : 32'h0000000C);
    end
    amp_fault <= 1'b0;
    limit_hit <= 1'b0;
    $display("t_boot mode %0d done", m);
  endtask
  task automatic t_step(input logic [7:0] ang);
    logic [15:0] s;
    s = ang < 8'h80 ? 16'h0BB8 : 16'hF448;
    wr(4'h1, 32'h00000BB8);
    wr(4'h2, 32'h00000001);
    wr(4'h3, {24'h0, ang});
    wr(4'h0, 32'h0000000E);
    ticks(100);
    check({pha, phb}, {-s, s});
    check(closed, 1'b0);
    ticks(256);
    check({pha, phb}, {16'h0000, s});
    wait_idle();
    check(rd, 32'h0000000C);
    rdw(4'h5);
    check(rd, 32'h00000000);
    check(comm, 1'b1);
    servo_cmd <= {8'h00, ang};
    ticks(6);
    check(pha, {8'h00, ang});
    check(angle_out, enc[7:0]);
    $display("t_step done");
  endtask
  task automatic t_step_bad(input int kind);
    wr(4'h0, kind == 2 ? 32'h0000000F : 32'h0000000E);
    ticks(50);
    move_en <= kind != 0;
    amp_fault <= kind == 1;
    limit_hit <= kind == 2;
    wait_idle();
    check(rd & 32'h00000006, 32'h00000002);
    check(closed, 1'b0);
    check(comm, 1'b0);
    move_en <= 1'b1;
    amp_fault <= 1'b0;
    limit_hit <= 1'b0;
    $display("t_step_bad %0d done", kind);
  endtask
  task automatic t_guess(input logic [1:0] m);
    wr(4'h1, 32'h00000FA0);
    wr(4'h2, 32'h00000005);
    wr(4'h0, {28'h0000000, 2'b11, m});
    rdw(4'h4);
    check(rd[0], 1'b1);
    wait_idle();
    check(rd, 32'h0000000C);
    $display("t_guess mode %0d done", m);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_boot(2'h0, 1'b1, 32'h00000000);
    t_boot(2'h1, 1'b0, 32'h00000000);
    t_boot(2'h2, 1'b1, 32'h00000000);
    t_boot(2'h1, 1'b1, 32'h0000000C);
    t_boot(2'h3, 1'b1, 32'h0000000C);
    t_step(8'h55);
    t_step(8'hAB);
    t_step_bad(0);
    t_step_bad(1);
    t_step_bad(2);
    t_guess(2'h0);
    t_guess(2'h1);
    conclude();
  end
endmodule // mps_motor_phasing_search_bench
`default_nettype wire

/* design/mps_motor_phasing_search.v */
// motor phasing search: top with avalon slave, search sequencer and outputs
// assumes servo_tick is synchronous; fault pins and encoder are asynchronous
//
// Function
// - positive command must make encoder count up
// - two-guess: probe twice, compute phase, close loop
// - mode 0 on command; mode 1 also at power-on
// - two-guess magnitude is torque command
// - two-guess duration in servo cycles
// - mode 2 on command; mode 3 also at power-on
// - stepper magnitude is forced phase current
// - stepper settle time is duration times 256
// - force 60 degree point, then zero point
// - enough movement: zero phase, clear error, close
// - too little movement: set error, kill loop
// - in stepper modes, outside power-on, fault or limit fails search
// - at power-on, fault and limit are ignored
// - phase offset signs select locked position
// - search needed at every power-up
// - angle setting in 1/256 of a cycle
// - search only when commutation is enabled
`default_nettype none
`include "mps_regs.vh"
module mps_motor_phasing_search (
  input wire clk,
  input wire sys_rst,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire servo_tick,
  input wire [31:0] enc_position,
  input wire amp_fault,
  input wire limit_hit,
  input wire [15:0] servo_cmd,
  output reg [15:0] phase_a_out_r,
  output reg [15:0] phase_b_out_r,
  output reg [7:0] comm_angle_r,
  output reg loop_closed_r,
  output reg commutating_r
);
  localparam ST_IDLE = 3'h0;
  localparam ST_G1 = 3'h1;
  localparam ST_G2 = 3'h2;
  localparam ST_GCALC = 3'h3;
  localparam ST_S1 = 3'h4;
  localparam ST_S2 = 3'h5;
  localparam ST_SCHK = 3'h6;

  reg [1:0] phasing_mode_select_r;
  reg commutation_enable_r;
  reg [15:0] search_magnitude_r;
  reg [15:0] search_duration_r;
  reg [7:0] phase_angle_setting_r;
  reg phase_err_r;
  reg [31:0] phase_pos_r;
  reg [31:0] resp1_r;
  reg [31:0] resp2_r;
  reg [2:0] state_r;
  reg power_on_r;
  reg boot_pending_r;
  reg reset_cmd_r;
  reg [31:0] start_pos_r;
  reg [31:0] enc_s1_r;
  reg [31:0] enc_s2_r;
  reg [31:0] enc_sb_r;
  reg [31:0] enc_sc_r;
  reg aborted_r;
  reg fault_s1_r;
  reg fault_s2_r;
  reg lim_s1_r;
  reg lim_s2_r;

  // two-stage synchronisers for fault and limit pins; encoder passes three stages and a stable-word check
  always @(posedge clk) begin
    if (sys_rst) begin
      enc_s1_r <= 32'h00000000;
      enc_s2_r <= 32'h00000000;
      enc_sb_r <= 32'h00000000;
      enc_sc_r <= 32'h00000000;
      fault_s1_r <= 1'b0;
      fault_s2_r <= 1'b0;
      lim_s1_r <= 1'b0;
      lim_s2_r <= 1'b0;
    end else begin
      enc_s1_r <= enc_position;
      enc_sb_r <= enc_s1_r;
      enc_sc_r <= enc_sb_r;
      // a count word caught mid-change differs from its neighbour: skip it
      if (enc_sb_r == enc_sc_r) begin
        enc_s2_r <= enc_sb_r;
      end
      fault_s1_r <= amp_fault;
      fault_s2_r <= fault_s1_r;
      lim_s1_r <= limit_hit;
      lim_s2_r <= lim_s1_r;
    end
  end

  wire bus_req;
  wire bus_wr;
  assign bus_req = (avs_read || avs_write) && avs_waitrequest;
  assign bus_wr = avs_write && avs_waitrequest;
  wire stepper;
  assign stepper = phasing_mode_select_r[1];

  // forced phase offsets for the current step
  wire [15:0] drv_a;
  wire [15:0] drv_b;
  mps_phase_drive u_drive (
    .mag(search_magnitude_r),
    .angle(phase_angle_setting_r),
    .zero_point(state_r == ST_S2),
    .phase_a(drv_a),
    .phase_b(drv_b)
  );

  reg tmr_load;
  reg [23:0] tmr_val;
  wire tmr_done;
  mps_tick_timer u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(tmr_load),
    .load_val(tmr_val),
    .tick(servo_tick),
    .done(tmr_done)
  );

  // step times: servo cycles or units of 256 servo cycles
  wire [23:0] dur_guess;
  wire [23:0] dur_step;
  assign dur_guess = {8'h00, search_duration_r};
  assign dur_step = {search_duration_r, 8'h00};

  wire [31:0] moved;
  assign moved = (enc_s2_r >= start_pos_r) ? enc_s2_r - start_pos_r :
                 start_pos_r - enc_s2_r;
  wire enough_move;
  assign enough_move = moved >=
    (`MPS_COUNTS_PER_CYCLE >> `MPS_SIXTEENTH_SHIFT);
  wire abort_fault;
  assign abort_fault = stepper && !power_on_r &&
    (fault_s2_r || lim_s2_r);

  // signed responses of the two guesses pick the quadrant
  wire [7:0] guess_angle;
  wire r1_neg;
  wire r2_neg;
  assign r1_neg = resp1_r[31];
  assign r2_neg = resp2_r[31];
  assign guess_angle = {r1_neg, r1_neg ^ r2_neg, 6'h20};

  wire start_req;
  assign start_req = (reset_cmd_r ||
    (boot_pending_r && phasing_mode_select_r[0])) &&
    commutation_enable_r;

  always @* begin
    tmr_load = 1'b0;
    tmr_val = dur_guess;
    if (state_r == ST_IDLE && start_req) begin
      tmr_load = 1'b1;
      tmr_val = stepper ? dur_step : dur_guess;
    end else if ((state_r == ST_G1 || state_r == ST_S1) && tmr_done) begin
      tmr_load = 1'b1;
      tmr_val = stepper ? dur_step : dur_guess;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      power_on_r <= 1'b1;
      boot_pending_r <= 1'b1;
      phase_err_r <= 1'b0;
      phase_pos_r <= 32'h00000000;
      resp1_r <= 32'h00000000;
      resp2_r <= 32'h00000000;
      start_pos_r <= 32'h00000000;
      aborted_r <= 1'b0;
      phase_a_out_r <= 16'h0000;
      phase_b_out_r <= 16'h0000;
      comm_angle_r <= 8'h00;
      loop_closed_r <= 1'b0;
      commutating_r <= 1'b0;
    end else begin
      if (state_r != ST_IDLE) begin
        boot_pending_r <= 1'b0;
      end
      case (state_r)
        ST_IDLE: begin
          if (start_req) begin
            start_pos_r <= enc_s2_r;
            loop_closed_r <= 1'b0;
            aborted_r <= 1'b0;
            // only the automatic start after reset runs as power-on
            power_on_r <= boot_pending_r && phasing_mode_select_r[0];
            commutating_r <= 1'b0;
            if (stepper) begin
              phase_a_out_r <= drv_a;
              phase_b_out_r <= drv_b;
              state_r <= ST_S1;
            end else begin
              // first guess at 0, torque on quadrature output
              phase_a_out_r <= 16'h0000;
              phase_b_out_r <= search_magnitude_r;
              state_r <= ST_G1;
            end
          end else begin
            if (!boot_pending_r) begin
              power_on_r <= 1'b0;
            end
            if (commutating_r) begin
              // commutated command follows the servo output
              phase_a_out_r <= servo_cmd;
              phase_b_out_r <= 16'h0000;
              comm_angle_r <= enc_s2_r[7:0] - phase_pos_r[7:0];
            end
          end
        end
        ST_G1: begin
          if (tmr_done) begin
            resp1_r <= enc_s2_r - start_pos_r;
            start_pos_r <= enc_s2_r;
            phase_a_out_r <= search_magnitude_r;
            phase_b_out_r <= 16'h0000;
            state_r <= ST_G2;
          end
        end
        ST_G2: begin
          if (tmr_done) begin
            resp2_r <= enc_s2_r - start_pos_r;
            state_r <= ST_GCALC;
          end
        end
        ST_GCALC: begin
          phase_pos_r <= {24'h000000, guess_angle - enc_s2_r[7:0]};
          phase_a_out_r <= 16'h0000;
          phase_b_out_r <= 16'h0000;
          phase_err_r <= 1'b0;
          commutating_r <= 1'b1;
          loop_closed_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        ST_S1: begin
          if (abort_fault) begin
            aborted_r <= 1'b1;
            state_r <= ST_SCHK;
          end else if (tmr_done) begin
            start_pos_r <= enc_s2_r;
            state_r <= ST_S2;
          end else begin
            phase_a_out_r <= drv_a;
            phase_b_out_r <= drv_b;
          end
        end
        ST_S2: begin
          phase_a_out_r <= drv_a;
          phase_b_out_r <= drv_b;
          if (abort_fault) begin
            aborted_r <= 1'b1;
          end
          if (abort_fault || tmr_done) begin
            state_r <= ST_SCHK;
          end
        end
        ST_SCHK: begin
          phase_a_out_r <= 16'h0000;
          phase_b_out_r <= 16'h0000;
          // a fault seen in either step fails the search even if it cleared
          if (enough_move && !abort_fault && !aborted_r) begin
            phase_pos_r <= 32'h00000000;
            phase_err_r <= 1'b0;
            commutating_r <= 1'b1;
            loop_closed_r <= 1'b1;
          end else begin
            phase_err_r <= 1'b1;
            commutating_r <= 1'b0;
            loop_closed_r <= 1'b0;
          end
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // avalon slave: one wait cycle, answer on the second edge
  always @(posedge clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
      phasing_mode_select_r <= `MPS_MODE_GUESS_CMD;
      commutation_enable_r <= 1'b0;
      search_magnitude_r <= `MPS_RST_MAG;
      search_duration_r <= `MPS_RST_DUR;
      phase_angle_setting_r <= `MPS_RST_ANGLE;
      reset_cmd_r <= 1'b0;
    end else begin
      if (state_r != ST_IDLE) begin
        reset_cmd_r <= 1'b0;
      end
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (bus_wr) begin
        case (avs_address)
          `MPS_OFS_CTRL: begin
            phasing_mode_select_r <= avs_writedata[1:0];
            commutation_enable_r <= avs_writedata[`MPS_CTRL_ENA_BIT];
            if (avs_writedata[`MPS_CTRL_RESET_BIT]) begin
              reset_cmd_r <= 1'b1;
            end
          end
          `MPS_OFS_MAG: search_magnitude_r <= avs_writedata[15:0];
          `MPS_OFS_DUR: search_duration_r <= avs_writedata[15:0];
          `MPS_OFS_ANGLE: phase_angle_setting_r <= avs_writedata[7:0];
          default: begin
          end
        endcase
      end
      if (bus_req) begin
        case (avs_address)
          `MPS_OFS_CTRL: avs_readdata <= {28'h0000000,
            reset_cmd_r, commutation_enable_r, phasing_mode_select_r};
          `MPS_OFS_MAG: avs_readdata <= {16'h0000, search_magnitude_r};
          `MPS_OFS_DUR: avs_readdata <= {16'h0000, search_duration_r};
          `MPS_OFS_ANGLE: avs_readdata <= {24'h000000,
            phase_angle_setting_r};
          `MPS_OFS_STATUS: avs_readdata <= {28'h0000000, commutating_r,
            loop_closed_r, phase_err_r, state_r != ST_IDLE};
          `MPS_OFS_PHASE: avs_readdata <= phase_pos_r;
          `MPS_OFS_RESP: avs_readdata <= resp1_r;
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // mps_motor_phasing_search
`default_nettype wire

/* design/mps_phase_drive.v */
// motor phasing search: picks signed phase a/b offsets for a forced position
// assumes magnitude and angle settings are stable while in use
`default_nettype none
module mps_phase_drive (
  input wire [15:0] mag,
  input wire [7:0] angle,
  input wire zero_point,
  output reg [15:0] phase_a,
  output reg [15:0] phase_b
);
  wire [15:0] neg_mag;
  assign neg_mag = 16'h0000 - mag;
  always @* begin
    // angle below 128: a=-m,b=+m is +60 deg; a=0,b=+m is 0 deg
    if (angle < 8'h80) begin
      phase_a = zero_point ? 16'h0000 : neg_mag;
      phase_b = mag;
    end else begin
      // reversed phasing shifts every position by 180 deg
      phase_a = zero_point ? 16'h0000 : mag;
      phase_b = neg_mag;
    end
  end
endmodule // mps_phase_drive
`default_nettype wire

/* design/mps_regs.vh */
// motor phasing search: mode codes, avalon offsets, field positions, timing
// assumes a single 50 MHz clock and one servo tick input
`ifndef MPS_REGS_VH
`define MPS_REGS_VH
`define MPS_MODE_GUESS_CMD 2'h0
`define MPS_MODE_GUESS_PWR 2'h1
`define MPS_MODE_STEP_CMD 2'h2
`define MPS_MODE_STEP_PWR 2'h3
`define MPS_OFS_CTRL 4'h0
`define MPS_OFS_MAG 4'h1
`define MPS_OFS_DUR 4'h2
`define MPS_OFS_ANGLE 4'h3
`define MPS_OFS_STATUS 4'h4
`define MPS_OFS_PHASE 4'h5
`define MPS_OFS_RESP 4'h6
`define MPS_CTRL_MODE_LO 0
`define MPS_CTRL_ENA_BIT 2
`define MPS_CTRL_RESET_BIT 3
`define MPS_ST_BUSY_BIT 0
`define MPS_ST_ERR_BIT 1
`define MPS_ST_LOOP_BIT 2
`define MPS_ST_COMM_BIT 3
`define MPS_RST_MAG 16'h0FA0
`define MPS_RST_DUR 16'h0005
`define MPS_RST_ANGLE 8'h55
`define MPS_STEP_UNIT_SHIFT 8
`define MPS_SIXTEENTH_SHIFT 4
`define MPS_COUNTS_PER_CYCLE 32'h00000400
`endif

/* design/mps_tick_timer.v */
// motor phasing search: down-counter decremented once per servo cycle
// assumes tick is a one-cycle pulse from the servo scheduler
`default_nettype none
module mps_tick_timer (
  input wire clk,
  input wire sys_rst,
  input wire load,
  input wire [23:0] load_val,
  input wire tick,
  output wire done
);
  reg [23:0] cnt_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      cnt_r <= 24'h000000;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (tick && cnt_r != 24'h000000) begin
      cnt_r <= cnt_r - 24'h000001;
    end
  end
  // not gated by load: the caller decides its load from done
  assign done = (cnt_r == 24'h000000);
endmodule // mps_tick_timer
`default_nettype wire
